// ---- rtl/ddcf_fifo.sv ----
// Deep dual-clock FIFO of 18-bit words with standard and fall-through
// timing, half/almost flags, offset programming, resets and reread.
// Assumes producer logic on wclk and consumer logic on rclk; pins other
// than rst and oe_n sampled synchronously to the clock of their side.
// Operation
// - Write word on wclk when enabled
// - Read on rclk when read enabled
// - Write and read clocks fully independent
// - Standard mode: output changes only on read
// - Fall-through: first word shows after three edges
// - Later words advance only on read enable
// - Mode pin sampled during full reset
// - Shared flags: empty/full or ready/space
// - Half and near flags in both modes
// - Separate programmable empty and full offsets
// - Load pin picks defaults and method
// - Serial load one bit per wclk
// - Parallel load offsets from data inputs
// - Offset readback on rclk with load
// - Full reset zeroes both pointers
// - Full reset sets flags for mode
// - Pointer reset keeps mode and offsets
// - Reread returns read pointer to start
// - Depth 32768 or 65536, 18-bit words
// - Fall-through units cascade without glue
// - Output enable only sets dout_oe; dout stays driven
// - Reread briefly forces empty indication
// - Near-full low above capacity minus offset
// - Near-empty low below empty offset
// - Half-level shows above half capacity
`include "ddcf_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module ddcf_fifo #(
  parameter int AW = `DDCF_ADDR_W,
  parameter int DW = `DDCF_DATA_W
) (
  input wire logic wclk,
  input wire logic rclk,
  input wire logic rst,
  input wire logic full_reset_n,
  input wire logic pointer_reset_n,
  input wire logic mode_sel_serial_in,
  input wire logic offset_access_n,
  input wire logic serial_load_en_n,
  input wire logic wen_n,
  input wire logic [DW-1:0] din,
  input wire logic ren_n,
  input wire logic reread_n,
  input wire logic oe_n,
  output logic [DW-1:0] dout,
  output logic dout_oe,
  output logic full_in_space_n,
  output logic empty_out_ready_n,
  output logic half_level_n,
  output logic near_empty_n,
  output logic near_full_n,
  output ddcf_pkg::ddcf_mode_t fall_through_mode
);
  import ddcf_pkg::*;

  // ==========================================
  // Sizes
  localparam int DEPTH = 1 << AW;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW:0] HALF_C = (AW+1)'(DEPTH / 2);
  localparam logic [AW-1:0] OFS_PAR = AW'(`DDCF_OFS_PAR_DEF);
  localparam logic [AW-1:0] OFS_SER = AW'(`DDCF_OFS_SER_DEF);
  localparam logic [5:0] SER_LAST = 6'(2 * AW - 1);

  // Gray to binary for pointers that crossed a domain
  function automatic logic [AW:0] g2b(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Storage: written on wclk, read on rclk
  logic [DW-1:0] mem [DEPTH];

  // ==========================================
  // Write domain state
  ddcf_mode_t wmode_ff; // Mode as seen by write side
  logic ser_ff; // Serial programming chosen
  logic [AW-1:0] eofs_ff; // Empty offset
  logic [AW-1:0] fofs_ff; // Full offset
  logic psel_ff; // Parallel: next word goes to full offset
  logic [5:0] sbit_ff; // Serial bit position
  logic [AW:0] wptr_ff; // Binary write pointer
  logic [AW:0] wgray_ff; // Gray copy sent across
  logic full_flag_ff; // Registered full/space pin
  logic half_ff; // Registered half-level pin
  logic nfull_ff; // Registered near-full pin
  logic [AW:0] rgray_q; // Read gray pointer, driven on rclk
  logic [AW:0] rgray_w; // Read pointer in write domain
  logic [AW:0] rptr_w;
  logic [AW:0] wcount;
  logic wfull;
  logic do_write;
  logic par_load;
  logic ser_load;
  logic [AW:0] nxt_wptr;

  assign rptr_w = g2b(rgray_w);
  assign wcount = wptr_ff - rptr_w;
  assign wfull = (wcount == DEPTH_C);
  // Offset access with load pin low steals the write strobe
  assign do_write = !wen_n && offset_access_n && !wfull;
  assign par_load = !wen_n && !offset_access_n && !ser_ff;
  assign ser_load = !serial_load_en_n && !offset_access_n && ser_ff;
  assign nxt_wptr = wptr_ff + (AW+1)'(1);

  // Read pointer crossing into the write side
  ddcf_sync #(.WIDTH(AW + 1)) u_rsync (
    .clk(wclk),
    .rst(rst),
    .d(rgray_q),
    .q(rgray_w)
  );

  // Memory write port; no reset so it maps to RAM
  always_ff @(posedge wclk) begin
    if (do_write && full_reset_n && pointer_reset_n) begin
      mem[wptr_ff[AW-1:0]] <= din;
    end
  end

  // Configuration caught while full reset is held
  always_ff @(posedge wclk or posedge rst) begin
    if (rst) begin
      wmode_ff <= DDCF_STD;
      ser_ff <= 1'b0;
      eofs_ff <= OFS_PAR;
      fofs_ff <= OFS_PAR;
      psel_ff <= 1'b0;
      sbit_ff <= 6'h00;
    end else if (!full_reset_n) begin
      // Pin is a strap here, a serial input afterwards
      wmode_ff <= mode_sel_serial_in ? DDCF_FALL_THROUGH_MODE : DDCF_STD;
      ser_ff <= offset_access_n;
      eofs_ff <= offset_access_n ? OFS_SER : OFS_PAR;
      fofs_ff <= offset_access_n ? OFS_SER : OFS_PAR;
      psel_ff <= 1'b0;
      sbit_ff <= 6'h00;
    end else if (par_load) begin
      // Alternate words: empty offset first, then full
      if (psel_ff) begin
        fofs_ff <= din[AW-1:0];
      end else begin
        eofs_ff <= din[AW-1:0];
      end
      psel_ff <= !psel_ff;
    end else if (ser_load) begin
      // Bits fill empty offset LSB first, then full offset
      if (sbit_ff < 6'(AW)) begin
        eofs_ff[sbit_ff[3:0]] <= mode_sel_serial_in;
      end else begin
        fofs_ff[4'(sbit_ff - 6'(AW))] <= mode_sel_serial_in;
      end
      sbit_ff <= (sbit_ff == SER_LAST) ? 6'h00 : sbit_ff + 6'h01;
    end
  end

  // Write pointer; both resets return it to location zero
  always_ff @(posedge wclk or posedge rst) begin
    if (rst) begin
      wptr_ff <= '0;
      wgray_ff <= '0;
    end else if (!full_reset_n || !pointer_reset_n) begin
      wptr_ff <= '0;
      wgray_ff <= '0;
    end else if (do_write) begin
      wptr_ff <= nxt_wptr;
      wgray_ff <= nxt_wptr ^ (nxt_wptr >> 1);
    end
  end

  // Write-side flags, refreshed every wclk
  always_ff @(posedge wclk or posedge rst) begin
    if (rst) begin
      full_flag_ff <= 1'b1;
      half_ff <= 1'b1;
      nfull_ff <= 1'b1;
    end else begin
      // Standard: low when full; fall-through: low when space
      if (wmode_ff == DDCF_FALL_THROUGH_MODE) begin
        full_flag_ff <= wfull;
      end else begin
        full_flag_ff <= !wfull;
      end
      half_ff <= !(wcount > HALF_C);
      nfull_ff <= !(wcount > DEPTH_C - (AW+1)'(fofs_ff));
    end
  end

  // ==========================================
  // Read domain state
  ddcf_mode_t rmode_ff; // Mode as seen by read side
  logic [AW:0] rptr_ff;
  logic [DW-1:0] dout_ff;
  logic valid_ff; // Fall-through: word waiting at outputs
  logic retx_ff; // One-cycle forced empty after reread
  logic rsel_ff; // Readback alternation
  logic empty_flag_ff;
  logic nempty_ff;
  logic [AW:0] wgray_r;
  logic [AW:0] wptr_r;
  logic [AW:0] rcount;
  logic rempty;
  logic rd_std;
  logic rd_fall_through_mode;
  logic rd_mem;
  logic rd_ofs;
  logic in_reset_r;
  logic [AW-1:0] eofs_r;
  logic [AW-1:0] fofs_r;
  logic [AW:0] nxt_rptr;

  // Write pointer and offsets crossing into the read side.
  // Offsets are assumed static while the read side uses them.
  ddcf_sync #(.WIDTH(AW + 1)) u_wsync (
    .clk(rclk),
    .rst(rst),
    .d(wgray_ff),
    .q(wgray_r)
  );
  ddcf_sync #(.WIDTH(AW)) u_esync (
    .clk(rclk),
    .rst(rst),
    .d(eofs_ff),
    .q(eofs_r)
  );
  ddcf_sync #(.WIDTH(AW)) u_fsync (
    .clk(rclk),
    .rst(rst),
    .d(fofs_ff),
    .q(fofs_r)
  );

  assign wptr_r = g2b(wgray_r);
  assign rcount = wptr_r - rptr_ff;
  assign rempty = (rcount == '0) || retx_ff;
  assign in_reset_r = !full_reset_n || !pointer_reset_n;
  assign rd_ofs = !ren_n && !offset_access_n;
  assign rd_std = !ren_n && offset_access_n && !rempty;
  // Fall-through: reload when output free or being consumed
  assign rd_fall_through_mode = offset_access_n && !rempty && (!valid_ff || !ren_n);
  assign rd_mem = (rmode_ff == DDCF_FALL_THROUGH_MODE) ? rd_fall_through_mode : rd_std;
  assign nxt_rptr = rptr_ff + (AW+1)'(1);

  // Mode captured on the read clock from the same strap
  always_ff @(posedge rclk or posedge rst) begin
    if (rst) begin
      rmode_ff <= DDCF_STD;
    end else if (!full_reset_n) begin
      rmode_ff <= mode_sel_serial_in ? DDCF_FALL_THROUGH_MODE : DDCF_STD;
    end
  end

  // Read pointer, output word and fall-through state
  always_ff @(posedge rclk or posedge rst) begin
    if (rst) begin
      rptr_ff <= '0;
      rgray_q <= '0;
      dout_ff <= '0;
      valid_ff <= 1'b0;
      retx_ff <= 1'b0;
      rsel_ff <= 1'b0;
    end else if (in_reset_r) begin
      // Both resets clear pointer and output register
      rptr_ff <= '0;
      rgray_q <= '0;
      dout_ff <= '0;
      valid_ff <= 1'b0;
      retx_ff <= 1'b0;
      rsel_ff <= 1'b0;
    end else if (!reread_n) begin
      // Write pointer and settings stay untouched
      rptr_ff <= '0;
      rgray_q <= '0;
      valid_ff <= 1'b0;
      retx_ff <= 1'b1;
    end else begin
      retx_ff <= 1'b0;
      if (rd_ofs) begin
        // Readback alternates empty then full offset
        dout_ff <= DW'(rsel_ff ? fofs_r : eofs_r);
        rsel_ff <= !rsel_ff;
      end else if (rd_mem) begin
        dout_ff <= mem[rptr_ff[AW-1:0]];
        rptr_ff <= nxt_rptr;
        rgray_q <= nxt_rptr ^ (nxt_rptr >> 1);
        valid_ff <= 1'b1;
      end else if (!ren_n) begin
        valid_ff <= 1'b0; // Consumed with nothing behind it
      end
    end
  end

  // Read-side flags
  always_ff @(posedge rclk or posedge rst) begin
    if (rst) begin
      empty_flag_ff <= 1'b0;
      nempty_ff <= 1'b0;
    end else begin
      // Standard: low when empty; fall-through: low when data shown
      if (rmode_ff == DDCF_FALL_THROUGH_MODE) begin
        empty_flag_ff <= !(rd_mem || (valid_ff && ren_n)) || !reread_n || in_reset_r;
      end else begin
        empty_flag_ff <= !(rempty && !rd_std) && !in_reset_r && reread_n;
      end
      nempty_ff <= !(rcount < (AW+1)'(eofs_r));
    end
  end

  // ==========================================
  // Outputs
  // Fall-through flags pair with enables of a following unit
  assign full_in_space_n = full_flag_ff;
  assign empty_out_ready_n = empty_flag_ff;
  assign half_level_n = half_ff;
  assign near_full_n = nfull_ff;
  assign near_empty_n = nempty_ff;
  assign dout = dout_ff;
  assign dout_oe = !oe_n;
  assign fall_through_mode = wmode_ff;

  // ==========================================
  // Checks
  chk_write_adv: assert property (@(posedge wclk) disable iff (rst)
    (do_write && full_reset_n && pointer_reset_n) |=> wptr_ff == (AW+1)'($past(wptr_ff) + 1))
    else $error("write pointer did not advance");
  chk_full_block: assert property (@(posedge wclk) disable iff (rst)
    wfull |-> !do_write)
    else $error("write accepted while full");
  chk_reset_ptr: assert property (@(posedge wclk) disable iff (rst)
    !pointer_reset_n |=> wptr_ff == '0)
    else $error("write pointer not cleared");
  chk_prs_keeps: assert property (@(posedge wclk) disable iff (rst)
    (full_reset_n && !pointer_reset_n && offset_access_n) |=> $stable(eofs_ff))
    else $error("pointer reset touched offsets");
  chk_mrs_dflt: assert property (@(posedge wclk) disable iff (rst)
    (!full_reset_n && offset_access_n) |=> fofs_ff == OFS_SER && ser_ff)
    else $error("serial default not loaded");
  chk_std_hold: assert property (@(posedge rclk) disable iff (rst)
    (rmode_ff == DDCF_STD && ren_n && reread_n && !in_reset_r) |=> $stable(dout_ff))
    else $error("standard output moved without read");
  chk_reread_ptr: assert property (@(posedge rclk) disable iff (rst)
    (!reread_n && !in_reset_r) |=> rptr_ff == '0 ##1 !empty_out_ready_n == (rmode_ff == DDCF_STD))
    else $error("reread did not rewind");
  chk_fall_through_mode_hold: assert property (@(posedge rclk) disable iff (rst)
    (rmode_ff == DDCF_FALL_THROUGH_MODE && valid_ff && ren_n && reread_n && !in_reset_r)
    |=> valid_ff && $stable(dout_ff))
    else $error("fall-through word moved without read");
  chk_oe_drive: assert property (@(posedge rclk) disable iff (rst)
    dout_oe == !oe_n)
    else $error("output enable mismatch");
  cov_fall_through_mode_first: cover property (@(posedge rclk) disable iff (rst)
    rmode_ff == DDCF_FALL_THROUGH_MODE && !valid_ff ##1 valid_ff);
  cov_reread: cover property (@(posedge rclk) disable iff (rst) !reread_n);
  cov_full: cover property (@(posedge wclk) disable iff (rst) wfull);
  cov_ser_load: cover property (@(posedge wclk) disable iff (rst) ser_load);
endmodule
`default_nettype wire

// ---- rtl/ddcf_pkg.sv ----
// Types shared by the deep dual-clock FIFO files.
// Assumes nothing of its surroundings.
package ddcf_pkg;
  // ==========================================
  // Timing mode chosen at full reset
  typedef enum logic {DDCF_STD, DDCF_FALL_THROUGH_MODE} ddcf_mode_t;
endpackage

// ---- rtl/ddcf_regs.svh ----
// Constants of the deep dual-clock FIFO: sizes, default offsets.
// Assumes inclusion by bare name from rtl files.
`ifndef DDCF_REGS_SVH
`define DDCF_REGS_SVH
// ==========================================
// Geometry
`define DDCF_ADDR_W 15
`define DDCF_DATA_W 18
// ==========================================
// Default partial-flag offsets
`define DDCF_OFS_PAR_DEF 127
`define DDCF_OFS_SER_DEF 1023
`endif

// ---- rtl/ddcf_sync.sv ----
// Two-flop synchroniser for a gray pointer or a quasi-static word.
// Assumes the source changes at most one bit at a time or is static.
`timescale 1ns/1ns
`default_nettype none
module ddcf_sync #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // ==========================================
  // Stages
  logic [WIDTH-1:0] meta_ff; // First stage, read only by the second
  logic [WIDTH-1:0] sync_ff; // Second stage, safe to use

  // Two flops in series
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule
`default_nettype wire

// ---- sim/ddcf_consumer.sv ----
// Consumer model for the read side of the dual-clock FIFO.
// Assumes the bench raises rd_cnt or rr_cnt just after a rising rclk edge.
`timescale 1ns/1ns
`default_nettype none
module ddcf_consumer (
  output logic rclk,
  input wire logic [15:0] rd_cnt,
  input wire logic [15:0] rr_cnt,
  output logic ren_n,
  output logic reread_n,
  output logic [15:0] served
);
  logic [15:0] rr_done; // Reread requests already strobed
  // ==========================================
  // Read clock
  // Period 14 ns with a lag, unrelated to the write clock
  initial begin
    rclk = 1'b0;
    #3;
    forever #7 rclk = ~rclk;
  end
  // ==========================================
  // Strobes
  // Each request is one strobe held over exactly one rising edge
  initial begin
    ren_n = 1'b1;
    reread_n = 1'b1;
    served = 16'h0;
    rr_done = 16'h0;
  end
  always @(negedge rclk) begin
    // Strobe only while a read is owed, so reads advance only on demand
    if (served != rd_cnt) begin
      ren_n <= 1'b0;
      served <= served + 16'h1;
    end else begin
      ren_n <= 1'b1;
    end
    // Reread is held low across one rising edge
    if (rr_done != rr_cnt) begin
      reread_n <= 1'b0;
      rr_done <= rr_done + 16'h1;
    end else begin
      reread_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- sim/ddcf_fifo_tb.sv ----
// Self-checking bench for the dual-clock FIFO: both modes, offsets, resets.
// Assumes the consumer model makes rclk and the read strobes.
`timescale 1ns/1ns
`default_nettype none
module ddcf_fifo_tb;
  import ddcf_pkg::*;
  localparam int AW = 10; // Depth 1024 keeps the fill test short
  logic wclk, rclk, rst, full_reset_n, pointer_reset_n, mode_sel_serial_in;
  logic offset_access_n, serial_load_en_n, wen_n, oe_n, ren_n, reread_n, dout_oe, seen;
  logic full_in_space_n, empty_out_ready_n, half_level_n, near_empty_n, near_full_n;
  logic [17:0] din, dout;
  ddcf_mode_t fall_through_mode;
  logic [15:0] rd_cnt, rr_cnt, served; // Requests to the consumer model
  int errors, comparisons;
  // ==========================================
  // Clock and instances
  initial wclk = 1'b0;
  always #5 wclk = ~wclk;
  ddcf_fifo #(.AW(AW), .DW(18)) dut_u (.wclk(wclk), .rclk(rclk), .rst(rst),
    .full_reset_n(full_reset_n), .pointer_reset_n(pointer_reset_n),
    .mode_sel_serial_in(mode_sel_serial_in), .offset_access_n(offset_access_n),
    .serial_load_en_n(serial_load_en_n), .wen_n(wen_n), .din(din), .ren_n(ren_n),
    .reread_n(reread_n), .oe_n(oe_n), .dout(dout), .dout_oe(dout_oe),
    .full_in_space_n(full_in_space_n), .empty_out_ready_n(empty_out_ready_n),
    .half_level_n(half_level_n), .near_empty_n(near_empty_n), .near_full_n(near_full_n),
    .fall_through_mode(fall_through_mode));
  ddcf_consumer con_u (.rclk(rclk), .rd_cnt(rd_cnt), .rr_cnt(rr_cnt), .ren_n(ren_n),
    .reread_n(reread_n), .served(served));
  // ==========================================
  // Reporting
  task automatic check(input string what, input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Flags packed full, empty, half, near empty, near full, mode
  task automatic flags(input logic [5:0] exp);
    check("flags", {full_in_space_n, empty_out_ready_n, half_level_n, near_empty_n,
      near_full_n, fall_through_mode}, exp);
  endtask
  // ==========================================
  // Access tasks; NBA drives avoid races with either clock
  task automatic wr(input int n, input logic [17:0] base);
    for (int k = 0; k < n; k++) begin
      @(negedge wclk);
      wen_n <= 1'b0;
      din <= base + 18'(k);
    end
    @(negedge wclk);
    wen_n <= 1'b1;
    repeat (6) @(negedge wclk); // Lets the pointer cross to the read side
  endtask
  task automatic strobe;
    @(posedge rclk);
    rd_cnt = rd_cnt + 16'h1;
    for (int k = 0; k < 50 && served != rd_cnt; k++) @(posedge rclk);
    if (served != rd_cnt) begin
      errors++; // Bounded wait ran out
      close_out();
    end
    repeat (3) @(negedge rclk);
  endtask
  task automatic rd(input logic [17:0] exp);
    strobe();
    check("dout", dout, exp);
  endtask
  task automatic ser(input logic [AW-1:0] v);
    // Serial offset bits, least significant first
    for (int k = 0; k < AW; k++) begin
      @(negedge wclk);
      serial_load_en_n <= 1'b0;
      mode_sel_serial_in <= v[k];
    end
    @(negedge wclk);
    serial_load_en_n <= 1'b1;
    repeat (6) @(negedge wclk);
  endtask
  // Reset pins are held over many edges of both clocks, straps steady
  task automatic resets(input logic full, input logic strap, input logic ld);
    @(negedge wclk);
    full_reset_n <= !full;
    pointer_reset_n <= full;
    mode_sel_serial_in <= strap;
    offset_access_n <= ld;
    repeat (8) @(negedge wclk);
    full_reset_n <= 1'b1;
    pointer_reset_n <= 1'b1;
    offset_access_n <= 1'b1;
    mode_sel_serial_in <= 1'b0;
    repeat (6) @(negedge wclk);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {full_reset_n, pointer_reset_n, offset_access_n, serial_load_en_n, wen_n} = 5'h1f;
    {mode_sel_serial_in, oe_n} = 2'h0;
    din = 18'h0;
    rd_cnt = 16'h0;
    rr_cnt = 16'h0;
    errors = 0;
    comparisons = 0;
    repeat (5) @(negedge wclk);
    rst <= 1'b0;
    // Standard mode, parallel method, offsets 127
    resets(1'b1, 1'b0, 1'b0);
    flags(6'h2a);
    wr(3, 18'h100);
    check("dout", dout, 18'h0);
    flags(6'h3a);
    rd(18'h100);
    rd(18'h101);
    offset_access_n <= 1'b0;
    rd(18'd127);
    rd(18'd127);
    wr(1, 18'd3);
    wr(1, 18'd5);
    rd(18'd3);
    rd(18'd5);
    offset_access_n <= 1'b1;
    $display("test standard done");
    // Pointer reset keeps offsets 3 and 5
    resets(1'b0, 1'b0, 1'b1);
    flags(6'h2a);
    wr(2, 18'h200);
    flags(6'h3a);
    wr(1, 18'h202);
    flags(6'h3e);
    rd(18'h200);
    @(posedge rclk);
    rr_cnt = rr_cnt + 16'h1;
    seen = 1'b0;
    repeat (6) begin
      @(negedge rclk);
      seen = seen | (empty_out_ready_n === 1'b0);
    end
    check("reread empty", seen, 1'b1);
    rd(18'h200);
    $display("test resets done");
    // Fill to full, then drain
    resets(1'b0, 1'b0, 1'b1);
    wr(512, 18'h0);
    check("half", half_level_n, 1'b1);
    wr(1, 18'd512);
    check("half", half_level_n, 1'b0);
    wr(506, 18'd513);
    check("near full", near_full_n, 1'b1);
    wr(1, 18'd1019);
    check("near full", near_full_n, 1'b0);
    check("full", full_in_space_n, 1'b1);
    wr(4, 18'd1020);
    check("full", full_in_space_n, 1'b0);
    wr(1, 18'h3ffff);
    for (int k = 0; k < 1024; k++) rd(18'(k));
    check("empty", empty_out_ready_n, 1'b0);
    rd(18'd1023);
    $display("test fill done");
    // Fall-through mode, serial method, offsets 1023
    resets(1'b1, 1'b1, 1'b1);
    flags(6'h1b);
    offset_access_n <= 1'b0;
    rd(18'd1023);
    rd(18'd1023);
    ser(10'd4);
    ser(10'd9);
    rd(18'd4);
    rd(18'd9);
    offset_access_n <= 1'b1;
    wr(2, 18'h300);
    repeat (6) @(negedge rclk);
    check("dout", dout, 18'h300);
    check("ready", empty_out_ready_n, 1'b0);
    repeat (6) @(negedge rclk);
    check("dout", dout, 18'h300);
    rd(18'h301);
    strobe();
    check("ready", empty_out_ready_n, 1'b1);
    @(negedge wclk);
    oe_n <= 1'b1;
    @(negedge wclk);
    check("oe", dout_oe, 1'b0);
    oe_n <= 1'b0;
    @(negedge wclk);
    check("oe", dout_oe, 1'b1);
    $display("test fall-through done");
    close_out();
  end
endmodule
`default_nettype wire
